// file: core/hws_host_wake.sv
// Ring/wake output, network indicator, sleep control and function level with APB registers
// How it works
// - Outgoing calls leave ring output high; they have no event that drops it.
// - A new short message drops ring output low for 120 ms.
// - Selected unsolicited reports drop ring output low for 120 ms.
// - Incoming voice call holds ring output low until the call is established.
// - Host hang-up during voice ringing releases ring output high.
// - Remote hang-up while ringing: high, 120 ms low, then high with the no-carrier report in the same cycle.
// - Incoming data call holds ring output low until the connection is up.
// - Host hang-up during data ringing releases ring output high.
// - A short message during call ringing releases ring output high.
// - Host drives sleep request high to allow sleep, low to wake.
// - Sleep mode 1 follows the sleep request level.
// - Sleep mode 2 sleeps after the serial port idles for the interval.
// - Data status blinks indicator 125 ms on, 125 ms off, only with link up.
// - Function level takes 0, 1 or 4 and resets to full function.
// - Level 0 rejects radio and SIM commands, serial port stays usable.
// - Level 4 rejects radio commands, serial port stays usable.
// - Writing level 1 returns to full function from 0 or 4.
// - Sleep request held low over 50 ms wakes the module in mode 1.
// - Idle interval is programmable and resets to 5 s.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module hws_host_wake
   import hws_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep_request_in,
   output logic             ring_wake_out,
   output logic             network_indicator_out,
   output logic             module_asleep,
   output logic             radio_enable,
   output logic             sim_enable,
   output logic             no_carrier_report
);
   hws_ri_state_type ri_state_q, ri_state_d;
   logic [6:0]  ri_ms_q, ri_ms_d;
   logic        ri_nc_q, ri_nc_d;
   logic        ri_out_q, ri_out_d;
   logic        nc_pulse_q, nc_pulse_d;
   logic [10:0] led_ms_q, led_ms_d;
   logic        led_on_q, led_on_d;
   logic [5:0]  wake_ms_q, wake_ms_d;
   logic [15:0] idle_ms_q, idle_ms_d;
   logic        asleep_q, asleep_d;
   logic [2:0]  fun_q, fun_d;
   logic [1:0]  smode_q, smode_d;
   logic [1:0]  net_q, net_d;
   logic [15:0] interval_q, interval_d;
   logic        link_q, link_d;
   logic        reject_q, reject_d;
   logic        nocarr_q, nocarr_d;
   logic        ph_q, ph_d;
   logic [31:0] rdata_q, rdata_d;
   logic        sreq_m_q, sreq_s_q;
   logic        ri_tick, ms_tick, ri_restart;
   logic        wr_fire, ev_wr, cmd_wr, ctrl_wr, st_wr, idle_wr, mapped;
   logic        ev_sms, ev_urc, ev_ring, ev_call_up, ev_hangup, ev_remote, ev_any;
   logic [10:0] on_ms, off_ms;
   logic [31:0] status;

   // =====================================================
   // Timebases
   hws_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_ri_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .restart (ri_restart),
      .tick    (ri_tick)
   );

   hws_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_ms_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .restart (1'b0),
      .tick    (ms_tick)
   );

   // =====================================================
   // Sleep request synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sreq_m_q <= 1'b0;
         sreq_s_q <= 1'b0;
      end else if (ce) begin
         sreq_m_q <= sleep_request_in;
         sreq_s_q <= sreq_m_q;
      end
   end

   // =====================================================
   // APB decode
   assign mapped  = (paddr == CTRL_OFS) || (paddr == EVENT_OFS) || (paddr == CMD_OFS) ||
                    (paddr == STATUS_OFS) || (paddr == IDLE_OFS);
   assign pready  = ce && psel && penable && ph_q;
   assign pslverr = pready && !mapped;
   assign prdata  = rdata_q;
   assign wr_fire = pready && pwrite && mapped;
   assign ctrl_wr = wr_fire && (paddr == CTRL_OFS);
   assign ev_wr   = wr_fire && (paddr == EVENT_OFS);
   assign cmd_wr  = wr_fire && (paddr == CMD_OFS);
   assign st_wr   = wr_fire && (paddr == STATUS_OFS);
   assign idle_wr = wr_fire && (paddr == IDLE_OFS);

   assign ev_sms     = ev_wr && pwdata[EV_SMS];
   assign ev_urc     = ev_wr && pwdata[EV_URC];
   assign ev_ring    = ev_wr && (pwdata[EV_VOICE] || pwdata[EV_DATA]);
   assign ev_call_up = ev_wr && pwdata[EV_CALL_UP];
   assign ev_hangup  = ev_wr && pwdata[EV_HANGUP];
   assign ev_remote  = ev_wr && pwdata[EV_REMOTE];
   assign ev_any     = ev_sms || ev_urc || ev_ring || ev_call_up || ev_hangup || ev_remote;

   always_comb begin
      status = 32'h0;
      status[ST_ASLEEP]   = asleep_q;
      status[ST_REJECT]   = reject_q;
      status[ST_NOCARR]   = nocarr_q;
      status[ST_LINK]     = link_q;
      status[ST_RING]     = ri_out_q;
      status[ST_NETLED]   = led_on_q;
      status[ST_SLEEPREQ] = sreq_s_q;
   end

   // =====================================================
   // Blink pattern select
   always_comb begin
      on_ms  = 11'(SEARCH_ON_MS);
      off_ms = 11'(SEARCH_OFF_MS);
      if (net_q == NET_DATA && link_q) begin
         on_ms  = 11'(DATA_BLINK_MS);
         off_ms = 11'(DATA_BLINK_MS);
      end else if (net_q != NET_SEARCH) begin
         on_ms  = 11'(IDLE_ON_MS);
         off_ms = 11'(IDLE_OFF_MS);
      end
   end

   // =====================================================
   // Next-state logic
   always_comb begin
      ri_state_d = ri_state_q;
      ri_ms_d    = ri_ms_q;
      ri_nc_d    = ri_nc_q;
      nc_pulse_d = 1'b0;
      ri_restart = 1'b0;
      led_ms_d   = led_ms_q;
      led_on_d   = led_on_q;
      wake_ms_d  = wake_ms_q;
      idle_ms_d  = idle_ms_q;
      asleep_d   = asleep_q;
      fun_d      = fun_q;
      smode_d    = smode_q;
      net_d      = net_q;
      interval_d = interval_q;
      link_d     = link_q;
      reject_d   = reject_q;
      nocarr_d   = nocarr_q;
      ph_d       = ph_q;
      rdata_d    = rdata_q;
      // Read data is captured in the setup phase so the access phase answers at once
      if (pready) begin
         ph_d = 1'b0;
      end else if (psel && !ph_q) begin
         ph_d    = 1'b1;
         rdata_d = 32'h0;
         case (paddr)
            CTRL_OFS:   rdata_d = {24'h0, net_q, smode_q, 1'b0, fun_q};
            STATUS_OFS: rdata_d = status;
            IDLE_OFS:   rdata_d = {16'h0, interval_q};
            default:    rdata_d = 32'h0;
         endcase
      end
      // Ring/wake sequencing; an outgoing call has no event, so the line stays high
      case (ri_state_q)
         RI_IDLE: begin
            if (ev_ring) begin
               ri_state_d = RI_RING;
            end else if (ev_sms || ev_urc) begin
               ri_state_d = RI_PULSE;
               ri_nc_d    = 1'b0;
               ri_restart = 1'b1;
               ri_ms_d    = 7'h00;
            end
         end
         RI_RING: begin
            if (ev_sms || ev_call_up || ev_hangup) begin
               ri_state_d = RI_IDLE;
            end else if (ev_remote) begin
               ri_state_d = RI_GAP;
            end
         end
         RI_GAP: begin
            // High until the next divider tick, up to one millisecond, marks the drop before the no-carrier pulse
            // Divider wraps on this tick by itself; a restart here would feed back into the tick
            if (ri_tick) begin
               ri_state_d = RI_PULSE;
               ri_nc_d    = 1'b1;
               ri_ms_d    = 7'h00;
            end
         end
         RI_PULSE: begin
            if (ev_ring) begin
               ri_state_d = RI_RING;
            end else if (ev_sms || ev_urc) begin
               ri_nc_d    = 1'b0;
               ri_restart = 1'b1;
               ri_ms_d    = 7'h00;
            end else if (ri_tick) begin
               if (ri_ms_q == 7'(PULSE_MS - 1)) begin
                  ri_state_d = RI_IDLE;
                  nc_pulse_d = ri_nc_q;
               end else begin
                  ri_ms_d = ri_ms_q + 7'h01;
               end
            end
         end
         default: ri_state_d = RI_IDLE;
      endcase
      ri_out_d = (ri_state_d == RI_IDLE) || (ri_state_d == RI_GAP);
      // Indicator phase counter; >= keeps a pattern change from overrunning a phase
      if (ms_tick) begin
         if (led_ms_q >= (led_on_q ? on_ms : off_ms) - 11'h001) begin
            led_ms_d = 11'h000;
            led_on_d = !led_on_q;
         end else begin
            led_ms_d = led_ms_q + 11'h001;
         end
      end
      // Sleep control
      case (smode_q)
         SLEEP_PIN: begin
            if (sreq_s_q) begin
               asleep_d  = 1'b1;
               wake_ms_d = 6'h00;
            end else if (asleep_q && ms_tick) begin
               if (wake_ms_q == 6'(WAKE_LOW_MS)) begin
                  asleep_d  = 1'b0;
                  wake_ms_d = 6'h00;
               end else begin
                  wake_ms_d = wake_ms_q + 6'h01;
               end
            end
         end
         SLEEP_IDLE: begin
            if (ev_wr && pwdata[EV_SERIAL]) begin
               asleep_d  = 1'b0;
               idle_ms_d = 16'h0000;
            end else if (!asleep_q && ms_tick) begin
               if (idle_ms_q + 16'h0001 >= interval_q) begin
                  asleep_d = 1'b1;
               end else begin
                  idle_ms_d = idle_ms_q + 16'h0001;
               end
            end
         end
         default: begin
            asleep_d  = 1'b0;
            wake_ms_d = 6'h00;
            idle_ms_d = 16'h0000;
         end
      endcase
      // Register writes
      if (ctrl_wr) begin
         if (pwdata[CTRL_FUN_LSB +: 3] == FUN_MIN || pwdata[CTRL_FUN_LSB +: 3] == FUN_FULL ||
             pwdata[CTRL_FUN_LSB +: 3] == FUN_NORF) begin
            fun_d = pwdata[CTRL_FUN_LSB +: 3];
         end
         if (pwdata[CTRL_SLEEP_LSB +: 2] != 2'h3) begin
            smode_d   = pwdata[CTRL_SLEEP_LSB +: 2];
            idle_ms_d = 16'h0000;
         end
         net_d = pwdata[CTRL_NET_LSB +: 2];
      end
      if (idle_wr) begin
         interval_d = pwdata[15:0];
      end
      if (ev_wr && pwdata[EV_LINK_DN]) begin
         link_d = 1'b0;
      end
      if (ev_wr && pwdata[EV_LINK_UP]) begin
         link_d = 1'b1;
      end
      // Sticky flags: set beats a same-cycle clear
      if (st_wr && pwdata[ST_REJECT]) begin
         reject_d = 1'b0;
      end
      if (st_wr && pwdata[ST_NOCARR]) begin
         nocarr_d = 1'b0;
      end
      if (cmd_wr && ((fun_q == FUN_MIN && (pwdata[CMD_RADIO] || pwdata[CMD_SIM])) ||
                     (fun_q == FUN_NORF && pwdata[CMD_RADIO]))) begin
         reject_d = 1'b1;
      end
      if (nc_pulse_d) begin
         nocarr_d = 1'b1;
      end
   end

   // =====================================================
   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ri_state_q <= RI_IDLE;
         ri_ms_q    <= 7'h00;
         ri_nc_q    <= 1'b0;
         ri_out_q   <= 1'b1;
         nc_pulse_q <= 1'b0;
         led_ms_q   <= 11'h000;
         led_on_q   <= 1'b0;
         wake_ms_q  <= 6'h00;
         idle_ms_q  <= 16'h0000;
         asleep_q   <= 1'b0;
         fun_q      <= FUN_FULL;
         smode_q    <= SLEEP_OFF;
         net_q      <= NET_SEARCH;
         interval_q <= IDLE_INTERVAL_RST;
         link_q     <= 1'b0;
         reject_q   <= 1'b0;
         nocarr_q   <= 1'b0;
         ph_q       <= 1'b0;
         rdata_q    <= 32'h0;
      end else if (ce) begin
         ri_state_q <= ri_state_d;
         ri_ms_q    <= ri_ms_d;
         ri_nc_q    <= ri_nc_d;
         ri_out_q   <= ri_out_d;
         nc_pulse_q <= nc_pulse_d;
         led_ms_q   <= led_ms_d;
         led_on_q   <= led_on_d;
         wake_ms_q  <= wake_ms_d;
         idle_ms_q  <= idle_ms_d;
         asleep_q   <= asleep_d;
         fun_q      <= fun_d;
         smode_q    <= smode_d;
         net_q      <= net_d;
         interval_q <= interval_d;
         link_q     <= link_d;
         reject_q   <= reject_d;
         nocarr_q   <= nocarr_d;
         ph_q       <= ph_d;
         rdata_q    <= rdata_d;
      end
   end

   assign ring_wake_out         = ri_out_q;
   assign network_indicator_out = led_on_q;
   assign module_asleep         = asleep_q;
   assign radio_enable          = (fun_q == FUN_FULL);
   assign sim_enable            = (fun_q != FUN_MIN);
   assign no_carrier_report     = nc_pulse_q;

   // =====================================================
   // Checks
   a_sms_starts_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_IDLE && ev_sms && !ev_ring) |=> (!ring_wake_out && ri_ms_q == 7'h00))
      else $error("sms did not start a low pulse");
   a_urc_starts_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_IDLE && ev_urc && !ev_ring) |=> !ring_wake_out)
      else $error("report did not start a low pulse");
   a_pulse_end_high: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_PULSE && ri_tick && ri_ms_q == 7'(PULSE_MS - 1) && !ev_any) |=> ring_wake_out)
      else $error("pulse did not end after its last millisecond");
   a_ring_holds_low: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_RING && !ev_any) |=> !ring_wake_out)
      else $error("ring line left low state without cause");
   a_hangup_release: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_RING && (ev_hangup || ev_call_up || ev_sms)) |=> ring_wake_out)
      else $error("ring line not released");
   a_remote_gap_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (ri_state_q == RI_RING && ev_remote && !ev_hangup && !ev_call_up && !ev_sms)
      |=> (ring_wake_out && ri_state_q == RI_GAP))
      else $error("remote hang-up did not raise the line first");
   a_no_carrier_edge: assert property (@(posedge pclk) disable iff (!presetn)
      no_carrier_report |-> (ring_wake_out && !$past(ring_wake_out) && nocarr_q))
      else $error("no-carrier report not at pulse end");
   a_fun_level_legal: assert property (@(posedge pclk) disable iff (!presetn)
      (fun_q == FUN_MIN || fun_q == FUN_FULL || fun_q == FUN_NORF))
      else $error("illegal function level held");
   a_reject_radio_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && fun_q == FUN_NORF && pwdata[CMD_RADIO]) |=> reject_q)
      else $error("radio command not rejected at level 4");
   a_mode1_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && smode_q == SLEEP_PIN && sreq_s_q && !ctrl_wr) |=> module_asleep)
      else $error("sleep request did not put module to sleep");
   a_mode1_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
      ($fell(module_asleep) && $past(smode_q) == SLEEP_PIN && !$past(ctrl_wr))
      |-> $past(wake_ms_q) == 6'(WAKE_LOW_MS))
      else $error("mode 1 woke before the low hold time");
endmodule

// file: core/hws_ms_tick.sv
// Millisecond tick generator with synchronous restart
`timescale 1ns/1ps
module hws_ms_tick #(
   parameter int TICK_CYCLES = 25000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic restart,
   output logic      tick
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // =====================================================
   // Divider
   always_comb begin
      cnt_d = cnt_q;
      if (restart) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end

   // Restart swallows the tick so a fresh pulse always gets whole milliseconds
   assign tick = ce && !restart && (cnt_q == LAST);
endmodule

// file: core/hws_pkg.sv
// Constants, register map and state types for the host wake and status block
package hws_pkg;
   // =====================================================
   // Clock and timebase
   localparam int CLK_PERIOD_NS   = 40;
   localparam int MS_NS           = 1000000;
   localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   // =====================================================
   // Times in milliseconds, except IDLE_SLEEP_S in seconds
   localparam int PULSE_MS        = 120;
   localparam int DATA_BLINK_MS   = 125;
   localparam int SEARCH_ON_MS    = 200;
   localparam int SEARCH_OFF_MS   = 200;
   localparam int IDLE_ON_MS      = 1800;
   localparam int IDLE_OFF_MS     = 200;
   localparam int WAKE_LOW_MS     = 50;
   localparam int IDLE_SLEEP_S    = 5;
   localparam logic [15:0] IDLE_INTERVAL_RST = 16'(IDLE_SLEEP_S * 1000);
   // =====================================================
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] EVENT_OFS  = 8'h04;
   localparam logic [7:0] CMD_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] IDLE_OFS   = 8'h10;
   // =====================================================
   // Control fields
   localparam int CTRL_FUN_LSB   = 0;
   localparam int CTRL_SLEEP_LSB = 4;
   localparam int CTRL_NET_LSB   = 6;
   localparam logic [2:0] FUN_MIN  = 3'h0;
   localparam logic [2:0] FUN_FULL = 3'h1;
   localparam logic [2:0] FUN_NORF = 3'h4;
   localparam logic [1:0] SLEEP_OFF   = 2'h0;
   localparam logic [1:0] SLEEP_PIN   = 2'h1;
   localparam logic [1:0] SLEEP_IDLE  = 2'h2;
   localparam logic [1:0] NET_SEARCH  = 2'h0;
   localparam logic [1:0] NET_IDLE    = 2'h1;
   localparam logic [1:0] NET_DATA    = 2'h2;
   // =====================================================
   // Event bits (write one to signal)
   localparam int EV_SMS      = 0;
   localparam int EV_URC      = 1;
   localparam int EV_VOICE    = 2;
   localparam int EV_DATA     = 3;
   localparam int EV_CALL_UP  = 4;
   localparam int EV_HANGUP   = 5;
   localparam int EV_REMOTE   = 6;
   localparam int EV_SERIAL   = 7;
   localparam int EV_LINK_UP  = 8;
   localparam int EV_LINK_DN  = 9;
   // =====================================================
   // Command class bits and status bits
   localparam int CMD_RADIO   = 0;
   localparam int CMD_SIM     = 1;
   localparam int ST_ASLEEP   = 0;
   localparam int ST_REJECT   = 1;
   localparam int ST_NOCARR   = 2;
   localparam int ST_LINK     = 3;
   localparam int ST_RING     = 4;
   localparam int ST_NETLED   = 5;
   localparam int ST_SLEEPREQ = 6;
   typedef enum logic [1:0] {RI_IDLE, RI_RING, RI_GAP, RI_PULSE} hws_ri_state_type;
endpackage

// file: tb/hws_host_model.sv
// Host side model driving the sleep request pin
`timescale 1ns/1ps
module hws_host_model #(
   parameter int MIN_LOW = 240
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic allow_sleep,
   output logic      sleep_request_in
);
   int low_cnt;
   // =====================================================
   // Pin level; once lowered it stays low long enough to wake the device
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_request_in <= 1'b0;
         low_cnt          <= 0;
      end else if (sleep_request_in) begin
         sleep_request_in <= allow_sleep;
         low_cnt          <= 0;
      end else if (low_cnt < MIN_LOW) begin
         low_cnt          <= low_cnt + 1;
      end else begin
         sleep_request_in <= allow_sleep;
      end
   end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the host wake and status block
`timescale 1ns/1ps
module tb_top
   import hws_pkg::*;
;
   localparam int TK = 4;
   logic        pclk, presetn, ce, psel, penable, pwrite, allow_sleep, err;
   logic        pready, pslverr, sleep_request_in, ring_wake_out, network_indicator_out;
   logic        module_asleep, radio_enable, sim_enable, no_carrier_report;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  lv [4] = '{FUN_MIN, FUN_NORF, 3'h3, FUN_FULL};
   logic [2:0]  cur;
   logic [1:0]  cmd;
   int          fail_count, comparisons, n;
   int          st [5] = '{EV_VOICE, EV_VOICE, EV_DATA, EV_DATA, EV_VOICE};
   int          en [5] = '{EV_CALL_UP, EV_HANGUP, EV_CALL_UP, EV_HANGUP, EV_SMS};

   hws_host_wake #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sleep_request_in, .ring_wake_out, .network_indicator_out,
      .module_asleep, .radio_enable, .sim_enable, .no_carrier_report);
   hws_host_model #(.MIN_LOW(60 * TK)) host (.pclk, .presetn, .allow_sleep, .sleep_request_in);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // =====================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 20);
      rd  = prdata;
      err = pslverr;
      chk(w < 20, 1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts following edges at which s still equals v
   task automatic run(ref logic s, input logic v, input int lim);
      n = 0;
      @(posedge pclk);
      while (s === v && n < lim) begin
         n++;
         @(posedge pclk);
      end
   endtask
   function automatic logic refused(input logic [2:0] l, input logic [1:0] c);
      return (l == FUN_MIN && c != 0) || (l == FUN_NORF && c[CMD_RADIO]);
   endfunction
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // =====================================================
   // Watchdog sized well above the expected run
   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      results();
   end
   // =====================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, allow_sleep} = '0;
      ce = 1'b1;
      paddr = '0;
      pwdata = '0;
      fail_count = 0;
      comparisons = 0;
      n = $urandom(69);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk({ring_wake_out, radio_enable, sim_enable}, 3'h7);
      apb(0, CTRL_OFS, 0);
      chk(rd, 32'h01);
      apb(0, IDLE_OFS, 0);
      chk(rd, 32'd5000);
      apb(0, 8'h20, 0);
      chk({err, rd}, {1'b1, 32'h0});
      run(ring_wake_out, 1'b1, 200);
      chk(n, 200);
      cur = FUN_FULL;
      foreach (lv[i]) begin
         apb(1, CTRL_OFS, {29'h0, lv[i]});
         if (lv[i] != 3'h3) cur = lv[i];
         apb(0, CTRL_OFS, 0);
         chk(rd[2:0], cur);
         chk({radio_enable, sim_enable}, {cur == FUN_FULL, cur != FUN_MIN});
         cmd = 2'($urandom_range(1, 3));
         apb(1, STATUS_OFS, 32'h2);
         apb(1, CMD_OFS, {30'h0, cmd});
         apb(0, STATUS_OFS, 0);
         chk(rd[ST_REJECT], refused(cur, cmd));
      end
      apb(1, EVENT_OFS, 32'h1 << EV_SMS);
      repeat ($urandom_range(10, 100)) @(posedge pclk);
      apb(1, EVENT_OFS, 32'h1 << EV_URC);
      run(ring_wake_out, 1'b0, 1000);
      chk(n, PULSE_MS * TK);
      apb(1, EVENT_OFS, 32'h1 << EV_SMS);
      // Enable low for 16 edges freezes the pulse, so the count after it is still a full pulse
      ce <= 1'b0;
      repeat (16) @(posedge pclk);
      ce <= 1'b1;
      run(ring_wake_out, 1'b0, 1000);
      chk(n, PULSE_MS * TK);
      foreach (st[i]) begin
         apb(1, EVENT_OFS, 32'h1 << st[i]);
         repeat ($urandom_range(5, 300)) @(posedge pclk);
         chk(ring_wake_out, 0);
         apb(1, EVENT_OFS, 32'h1 << en[i]);
         run(ring_wake_out, 1'b1, 8);
         chk(n, 8);
      end
      apb(1, EVENT_OFS, 32'h1 << EV_VOICE);
      apb(1, EVENT_OFS, 32'h1 << EV_REMOTE);
      run(ring_wake_out, 1'b1, 10);
      chk(n >= 1 && n <= TK, 1);
      run(ring_wake_out, 1'b0, 1000);
      chk(n, PULSE_MS * TK - 1);
      chk(no_carrier_report, 1);
      apb(0, STATUS_OFS, 0);
      chk(rd[ST_NOCARR], 1);
      apb(1, CTRL_OFS, {24'h0, NET_DATA, 6'h1});
      apb(1, EVENT_OFS, 32'h1 << EV_LINK_UP);
      run(network_indicator_out, 1'b1, 3000);
      run(network_indicator_out, 1'b0, 3000);
      run(network_indicator_out, 1'b1, 3000);
      chk(n, DATA_BLINK_MS * TK - 1);
      run(network_indicator_out, 1'b0, 3000);
      chk(n, DATA_BLINK_MS * TK - 1);
      apb(1, IDLE_OFS, 32'd10);
      apb(1, CTRL_OFS, {26'h0, SLEEP_IDLE, 4'h1});
      repeat (30) @(posedge pclk);
      chk(module_asleep, 0);
      repeat (20) @(posedge pclk);
      chk(module_asleep, 1);
      apb(1, EVENT_OFS, 32'h1 << EV_SERIAL);
      @(posedge pclk);
      chk(module_asleep, 0);
      apb(1, CTRL_OFS, {26'h0, SLEEP_PIN, 4'h1});
      allow_sleep <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(module_asleep, 1);
      allow_sleep <= 1'b0;
      repeat (195) @(posedge pclk);
      chk(module_asleep, 1);
      repeat (25) @(posedge pclk);
      chk(module_asleep, 0);
      results();
   end
endmodule
